/* rtl/ccsl_pkg.sv */
// constants and types for the cancel coefficient shadow loader
// ============================================================
// Notes on behaviour
// [RQ1] 768-entry shadow memory behind pointer and data
// [RQ2] host loads pointer, then writes data port
// [RQ3] each data access post-increments the pointer
// [RQ4] freshly written pointer is used immediately
// [RQ5] eight canceler RAMs, each with own pointer; code drives one shared ram_addr_o and a ram_we_o bit per RAM
// [RQ6] 32 cancelers, four per RAM, grouped
// [RQ7] stage RAM counts must sum to eight max; code stores whatever value is written, without checking the sum
// [RQ8] host writes reach shadow memory only
// [RQ9] copy one value per clock to masked RAMs
// [RQ10] copy moves three times tap count values
// [RQ11] all masked RAMs written together, waits idle
// [RQ12] copy trigger source selectable, four sources
// [RQ13] copy done sets flag 6, maskable interrupt
// [RQ14] stage counts let groups go offline
// [RQ15] timer event loads 32-bit counter from period
// [RQ16] timer decrements every internal clock
// [RQ17] at zero reload if periodic, else stop
// [RQ18] timer expiry interrupts when enable bit 4
// [RQ19] program period before enabling timer
// [RQ20] one-time mode suggested for software start
// [RQ21] shadow sections start at 0, 256, 512
// [RQ22] trigger during copy is ignored
// [RQ23] pointer wraps from 767 to 0
package ccsl_pkg;
    // ============================================================
    // sizes
    localparam int SHADOW_DEPTH = 768;
    localparam int SECTION_SIZE = 256;
    localparam int NUM_RAMS = 8;
    localparam int CANCELERS_PER_RAM = 4;
    localparam int NUM_STAGES = 4;
    localparam logic [9:0] PTR_LAST = 10'h2ff;
    localparam logic [9:0] SEC1_BASE = 10'h100;
    localparam logic [9:0] SEC2_BASE = 10'h200;
    // ============================================================
    // register byte offsets
    localparam logic [7:0] REG_PTR = 8'h00;
    localparam logic [7:0] REG_DATA = 8'h04;
    localparam logic [7:0] REG_TAPS = 8'h08;
    localparam logic [7:0] REG_TARGET = 8'h0c;
    localparam logic [7:0] REG_COPY_SRC = 8'h10;
    localparam logic [7:0] REG_SW_TRIG = 8'h14;
    localparam logic [7:0] REG_TIMER_SRC = 8'h18;
    localparam logic [7:0] REG_PERIOD_HI = 8'h1c;
    localparam logic [7:0] REG_PERIOD_LO = 8'h20;
    localparam logic [7:0] REG_TIMER_CONTROL = 8'h24;
    localparam logic [7:0] REG_STAGE_CNT = 8'h28;
    localparam logic [7:0] REG_INT_FLAG = 8'h2c;
    localparam logic [7:0] REG_INT_EN = 8'h30;
    localparam logic [7:0] REG_STATUS = 8'h34;
    localparam logic [7:0] REG_TIMER_VAL = 8'h38;
    // ============================================================
    // field positions and reset values
    localparam int FLAG_TIMER_BIT = 4;
    localparam int FLAG_COPY_BIT = 6;
    localparam int TIMER_PERIODIC_BIT = 15;
    localparam int SW_TRIG_COPY_BIT = 0;
    localparam int SW_TRIG_TIMER_BIT = 1;
    localparam logic [8:0] TAPS_RESET = 9'h000;
    localparam logic [7:0] TARGET_RESET = 8'h00;
    localparam logic [31:0] PERIOD_RESET = 32'h0000_0000;
    // ============================================================
    // trigger sources and copy states
    typedef enum logic [1:0] {
        CCSL_SRC_SOFTWARE = 2'b00,
        CCSL_SRC_TIMER = 2'b01,
        CCSL_SRC_SYNC_A = 2'b10,
        CCSL_SRC_SYNC_B = 2'b11
    } ccsl_src_t;
    typedef enum logic [1:0] {
        CCSL_COPY_IDLE = 2'b00,
        CCSL_COPY_WAIT = 2'b01,
        CCSL_COPY_RUN = 2'b10
    } ccsl_copy_state_t;
endpackage : ccsl_pkg

/* rtl/ccsl_sync2.sv */
// two-flop synchroniser for one pin level
`timescale 1ns/1ps
module ccsl_sync2 (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // level
    input wire logic d_i,
    output logic q_o
);
    logic meta;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta <= 1'b0;
            q_o <= 1'b0;
        end else begin
            meta <= d_i;
            q_o <= meta;
        end
    end
endmodule : ccsl_sync2

/* rtl/ccsl_timer.sv */
// 32-bit software timer with one-time and periodic modes
`timescale 1ns/1ps
module ccsl_timer (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // control
    input wire logic enable_i,
    input wire logic periodic_i,
    input wire logic start_i,
    input wire logic [31:0] period_i,
    // status
    output logic running_o,
    output logic [31:0] count_o,
    output logic expire_o
);
    // ============================================================
    // counter
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            running_o <= 1'b0;
            count_o <= ccsl_pkg::PERIOD_RESET;
            expire_o <= 1'b0;
        end else begin
            expire_o <= 1'b0;
            if (!enable_i) begin
                running_o <= 1'b0;
            end else if (start_i) begin
                count_o <= period_i; // RQ15
                running_o <= 1'b1;
            end else if (running_o) begin
                if (count_o == 32'h0000_0000) begin
                    expire_o <= 1'b1;
                    if (periodic_i) begin
                        count_o <= period_i; // RQ17
                    end else begin
                        running_o <= 1'b0; // RQ17
                    end
                end else begin
                    count_o <= count_o - 32'h0000_0001; // RQ16
                end
            end
        end
    end
endmodule : ccsl_timer

/* rtl/ccsl_loader.sv */
// shadow coefficient memory, copy engine and register slave
`timescale 1ns/1ps
module ccsl_loader #(
    parameter int DATA_W = 16,
    parameter int NUM_RAMS = ccsl_pkg::NUM_RAMS
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // sync pins
    input wire logic sync_a_i,
    input wire logic sync_b_i,
    // canceler ram side
    input wire logic [NUM_RAMS-1:0] ram_idle_i,
    output logic [NUM_RAMS-1:0] ram_we_o,
    output logic [9:0] ram_addr_o,
    output logic [DATA_W-1:0] ram_data_o,
    // stage allocation
    output logic [15:0] stage_ram_count_o,
    // interrupt
    output logic irq_o
);
    // ============================================================
    // registers
    logic [DATA_W-1:0] shadow [0:ccsl_pkg::SHADOW_DEPTH-1];
    logic [9:0] ptr;
    logic [8:0] taps;
    logic [NUM_RAMS-1:0] copy_target_select;
    ccsl_pkg::ccsl_src_t copy_src;
    ccsl_pkg::ccsl_src_t timer_src;
    logic timer_periodic;
    logic [15:0] timer_period_high;
    logic [15:0] timer_period_low;
    logic timer_control;
    logic [15:0] stage_ram_count;
    logic [7:0] int_flag;
    logic [7:0] int_en;
    logic [DATA_W-1:0] rd_data;
    // ============================================================
    // bus decode
    logic req;
    logic wr;
    logic rd;
    logic sw_copy;
    logic sw_timer;
    logic data_acc;
    logic ptr_wr;
    logic flag_clr_wr;
    logic rd_data_phase;
    assign req = cyc_i && stb_i && !ack_o;
    assign wr = req && we_i && sel_i[0];
    assign rd = req && !we_i;
    assign ptr_wr = wr && adr_i == ccsl_pkg::REG_PTR;
    // second cycle of a data read is the same access, no extra step
    assign data_acc = (wr || (rd && !rd_data_phase))
        && adr_i == ccsl_pkg::REG_DATA; // RQ3
    assign sw_copy = wr && adr_i == ccsl_pkg::REG_SW_TRIG
        && dat_i[ccsl_pkg::SW_TRIG_COPY_BIT];
    assign sw_timer = wr && adr_i == ccsl_pkg::REG_SW_TRIG
        && dat_i[ccsl_pkg::SW_TRIG_TIMER_BIT];
    assign flag_clr_wr = wr && adr_i == ccsl_pkg::REG_INT_FLAG;
    // ============================================================
    // sync pins
    logic sync_a;
    logic sync_b;
    logic sync_a_d;
    logic sync_b_d;
    ccsl_sync2 u_sync_a (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(sync_a_i),
        .q_o(sync_a)
    );
    ccsl_sync2 u_sync_b (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(sync_b_i),
        .q_o(sync_b)
    );
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_a_d <= 1'b0;
            sync_b_d <= 1'b0;
        end else begin
            sync_a_d <= sync_a;
            sync_b_d <= sync_b;
        end
    end
    logic rise_a;
    logic rise_b;
    assign rise_a = sync_a && !sync_a_d;
    assign rise_b = sync_b && !sync_b_d;
    // ============================================================
    // timer
    logic timer_start;
    logic timer_expire;
    logic timer_running;
    logic [31:0] timer_count;
    logic copy_trig;
    always_comb begin
        case (timer_src) // RQ12
            ccsl_pkg::CCSL_SRC_SOFTWARE: timer_start = sw_timer;
            ccsl_pkg::CCSL_SRC_SYNC_A: timer_start = rise_a;
            ccsl_pkg::CCSL_SRC_SYNC_B: timer_start = rise_b;
            default: timer_start = sw_timer;
        endcase
    end
    ccsl_timer u_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .enable_i(timer_control),
        .periodic_i(timer_periodic),
        .start_i(timer_start),
        .period_i({timer_period_high, timer_period_low}),
        .running_o(timer_running),
        .count_o(timer_count),
        .expire_o(timer_expire)
    );
    always_comb begin
        case (copy_src) // RQ12
            ccsl_pkg::CCSL_SRC_SOFTWARE: copy_trig = sw_copy;
            ccsl_pkg::CCSL_SRC_TIMER: copy_trig = timer_expire;
            ccsl_pkg::CCSL_SRC_SYNC_A: copy_trig = rise_a;
            ccsl_pkg::CCSL_SRC_SYNC_B: copy_trig = rise_b;
            default: copy_trig = 1'b0;
        endcase
    end
    // ============================================================
    // copy engine
    ccsl_pkg::ccsl_copy_state_t state;
    logic [8:0] tap_idx;
    logic [1:0] section;
    logic [NUM_RAMS-1:0] copy_mask;
    logic copy_done;
    logic [9:0] sec_base;
    always_comb begin
        case (section) // RQ21
            2'd1: sec_base = ccsl_pkg::SEC1_BASE;
            2'd2: sec_base = ccsl_pkg::SEC2_BASE;
            default: sec_base = 10'h000;
        endcase
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= ccsl_pkg::CCSL_COPY_IDLE;
            tap_idx <= 9'h000;
            section <= 2'd0;
            copy_mask <= '0;
            copy_done <= 1'b0;
        end else begin
            copy_done <= 1'b0;
            case (state)
                ccsl_pkg::CCSL_COPY_IDLE: begin
                    // triggers only honoured here
                    if (copy_trig && taps != 9'h000) begin // RQ22
                        copy_mask <= copy_target_select; // RQ9
                        tap_idx <= 9'h000;
                        section <= 2'd0;
                        state <= ccsl_pkg::CCSL_COPY_WAIT;
                    end
                end
                ccsl_pkg::CCSL_COPY_WAIT: begin
                    // wait for every target ram to go idle
                    if ((copy_mask & ~ram_idle_i) == '0) begin // RQ11
                        state <= ccsl_pkg::CCSL_COPY_RUN;
                    end
                end
                ccsl_pkg::CCSL_COPY_RUN: begin
                    if (tap_idx == taps - 9'h001) begin // RQ10
                        tap_idx <= 9'h000;
                        if (section == 2'd2) begin
                            state <= ccsl_pkg::CCSL_COPY_IDLE;
                            copy_done <= 1'b1;
                        end else begin
                            section <= section + 2'd1;
                        end
                    end else begin
                        tap_idx <= tap_idx + 9'h001;
                    end
                end
                default: state <= ccsl_pkg::CCSL_COPY_IDLE;
            endcase
        end
    end
    // one value per clock to all masked rams at once
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ram_we_o <= '0;
            ram_addr_o <= 10'h000;
            ram_data_o <= '0;
        end else begin
            if (state == ccsl_pkg::CCSL_COPY_RUN) begin
                ram_we_o <= copy_mask; // RQ5 RQ9 RQ11
                ram_addr_o <= sec_base + {1'b0, tap_idx};
                ram_data_o <= shadow[sec_base + {1'b0, tap_idx}];
            end else begin
                ram_we_o <= '0;
            end
        end
    end
    // ============================================================
    // shadow memory, host side only
    always_ff @(posedge clk_i) begin
        if (wr && adr_i == ccsl_pkg::REG_DATA) begin
            shadow[ptr] <= dat_i[DATA_W-1:0]; // RQ8 RQ1
        end
        rd_data <= shadow[ptr];
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ptr <= 10'h000;
        end else if (ptr_wr) begin
            ptr <= (dat_i[9:0] > ccsl_pkg::PTR_LAST) ? 10'h000
                : dat_i[9:0]; // RQ4
        end else if (data_acc) begin
            ptr <= (ptr == ccsl_pkg::PTR_LAST) ? 10'h000
                : ptr + 10'h001; // RQ3 RQ23
        end
    end
    // ============================================================
    // config registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            taps <= ccsl_pkg::TAPS_RESET;
            copy_target_select <= '0;
            copy_src <= ccsl_pkg::CCSL_SRC_SOFTWARE;
            timer_src <= ccsl_pkg::CCSL_SRC_SOFTWARE;
            timer_periodic <= 1'b0;
            timer_period_high <= 16'h0000;
            timer_period_low <= 16'h0000;
            timer_control <= 1'b0;
            stage_ram_count <= 16'h0000;
            int_en <= 8'h00;
        end else if (wr) begin
            case (adr_i)
                ccsl_pkg::REG_TAPS: taps <= dat_i[8:0];
                ccsl_pkg::REG_TARGET:
                    copy_target_select <= dat_i[NUM_RAMS-1:0];
                ccsl_pkg::REG_COPY_SRC:
                    copy_src <= ccsl_pkg::ccsl_src_t'(dat_i[1:0]);
                ccsl_pkg::REG_TIMER_SRC: begin
                    timer_src <= ccsl_pkg::ccsl_src_t'(dat_i[1:0]);
                    timer_periodic <=
                        dat_i[ccsl_pkg::TIMER_PERIODIC_BIT];
                end
                ccsl_pkg::REG_PERIOD_HI: timer_period_high <= dat_i[15:0];
                ccsl_pkg::REG_PERIOD_LO: timer_period_low <= dat_i[15:0];
                ccsl_pkg::REG_TIMER_CONTROL: timer_control <= dat_i[0];
                ccsl_pkg::REG_STAGE_CNT:
                    stage_ram_count <= dat_i[15:0]; // RQ14
                ccsl_pkg::REG_INT_EN: int_en <= dat_i[7:0];
                default: ;
            endcase
        end
    end
    assign stage_ram_count_o = stage_ram_count; // RQ6 RQ14
    // ============================================================
    // interrupt flags: write one to clear, set wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            int_flag <= 8'h00;
        end else begin
            int_flag <= (int_flag & ~(flag_clr_wr ? dat_i[7:0] : 8'h00))
                | {1'b0, copy_done, 1'b0, timer_expire, 4'h0}; // RQ13 RQ18
        end
    end
    assign irq_o = |(int_flag & int_en); // RQ13 RQ18
    // ============================================================
    // read mux and ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
            rd_data_phase <= 1'b0;
        end else begin
            ack_o <= 1'b0;
            rd_data_phase <= 1'b0;
            if (rd && adr_i == ccsl_pkg::REG_DATA && !rd_data_phase) begin
                // memory read needs one more cycle
                rd_data_phase <= 1'b1;
            end else if (rd_data_phase) begin
                ack_o <= 1'b1;
                dat_o <= 32'h0000_0000 | rd_data;
            end else if (req) begin
                ack_o <= 1'b1;
                case (adr_i)
                    ccsl_pkg::REG_PTR: dat_o <= {22'h0, ptr};
                    ccsl_pkg::REG_TAPS: dat_o <= {23'h0, taps};
                    ccsl_pkg::REG_TARGET:
                        dat_o <= 32'h0000_0000 | copy_target_select;
                    ccsl_pkg::REG_COPY_SRC: dat_o <= {30'h0, copy_src};
                    ccsl_pkg::REG_TIMER_SRC:
                        dat_o <= {16'h0, timer_periodic, 13'h0, timer_src};
                    ccsl_pkg::REG_PERIOD_HI:
                        dat_o <= {16'h0, timer_period_high};
                    ccsl_pkg::REG_PERIOD_LO:
                        dat_o <= {16'h0, timer_period_low};
                    ccsl_pkg::REG_TIMER_CONTROL: dat_o <= {31'h0, timer_control};
                    ccsl_pkg::REG_STAGE_CNT: dat_o <= {16'h0, stage_ram_count};
                    ccsl_pkg::REG_INT_FLAG: dat_o <= {24'h0, int_flag};
                    ccsl_pkg::REG_INT_EN: dat_o <= {24'h0, int_en};
                    ccsl_pkg::REG_STATUS:
                        dat_o <= {28'h0, timer_running, 1'b0, state};
                    ccsl_pkg::REG_TIMER_VAL: dat_o <= timer_count;
                    default: dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule : ccsl_loader

/* verif/ccsl_loader_props.sv */
// port assertions for the shadow loader
`timescale 1ns/1ps
module ccsl_loader_props #(
    parameter int NUM_RAMS = 8
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // bus
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // canceler side
    input wire logic [NUM_RAMS-1:0] ram_idle_i,
    input wire logic [NUM_RAMS-1:0] ram_we_o,
    input wire logic [9:0] ram_addr_o,
    input wire logic [15:0] stage_ram_count_o,
    input wire logic irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ============================================================
    // sequences
    sequence req_s;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence burst_s;
        (|ram_we_o) && (|$past(ram_we_o));
    endsequence
    sequence burst_go_s;
        $rose(|ram_we_o);
    endsequence
    // ============================================================
    // bus
    ack_bound_a: assert property (req_s |-> ##[1:2] ack_o)
        else $error("ack late");
    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i))
        else $error("ack without request");
    unmapped_zero_a: assert property (ack_o && !we_i && adr_i > 8'h38
        |-> dat_o == 32'h0)
        else $error("unmapped read not zero");
    stage_cause_a: assert property ($changed(stage_ram_count_o)
        |-> $past(cyc_i && stb_i && we_i && adr_i == 8'h28))
        else $error("stage counts moved without write");
    // ============================================================
    // copy burst
    burst_start_a: assert property (burst_go_s |-> ram_addr_o == 10'h0)
        else $error("copy not starting at zero");
    burst_mask_a: assert property (burst_s |-> ram_we_o == $past(ram_we_o))
        else $error("target set changed mid copy");
    burst_addr_a: assert property (burst_s |->
        ram_addr_o == $past(ram_addr_o) + 10'h1 ||
        (ram_addr_o[7:0] == 8'h0 && ram_addr_o != 10'h0))
        else $error("copy address out of order");
    idle_wait_a: assert property (burst_go_s
        |-> ($past(ram_idle_i, 2) & ram_we_o) == ram_we_o)
        else $error("copy into busy ram");
    reset_quiet_a: assert property (disable iff (1'b0) rst_i
        |=> !ack_o && ram_we_o == '0 && !irq_o)
        else $error("outputs active after reset");
endmodule : ccsl_loader_props

/* verif/ccsl_ram_model.sv */
// eight canceler rams as seen from the copy port
`timescale 1ns/1ps
module ccsl_ram_model (
    // clock
    input wire logic clk_i,
    // bench control
    input wire logic [7:0] busy_i,
    // copy port
    input wire logic [7:0] ram_we_i,
    input wire logic [9:0] ram_addr_i,
    input wire logic [15:0] ram_data_i,
    output logic [7:0] ram_idle_o
);
    logic [15:0] mem [8][768];
    int n_writes = 0;
    // busy stands for cancelers reading; only the bench commands it
    assign ram_idle_o = ~busy_i;
    always_ff @(posedge clk_i) begin
        if (ram_we_i != 8'h00) begin
            n_writes <= n_writes + 1;
        end
        for (int r = 0; r < 8; r++) begin
            if (ram_we_i[r]) begin
                mem[r][ram_addr_i] <= ram_data_i;
            end
        end
    end
endmodule : ccsl_ram_model

/* verif/ccsl_loader_test.sv */
// self-checking bench for the shadow loader
`timescale 1ns/1ps
module ccsl_loader_test;
    // ============================================================
    // signals
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'hf;
    logic [31:0] dat_i = 32'h0;
    logic sync_a_i = 1'b0;
    logic sync_b_i = 1'b0;
    logic [7:0] busy = 8'h00;
    logic [31:0] dat_o;
    logic ack_o;
    logic irq_o;
    logic [7:0] ram_idle_i;
    logic [7:0] ram_we_o;
    logic [9:0] ram_addr_o;
    logic [15:0] ram_data_o;
    logic [15:0] stage_ram_count_o;
    int n_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    int base;
    typedef struct {
        logic [7:0] a;
        logic [31:0] w;
        logic [31:0] e;
    } ccsl_row_t;
    ccsl_row_t rows [8] = '{'{8'h08, 32'hffff, 32'h1ff},
        '{8'h0c, 32'h3a5, 32'ha5}, '{8'h10, 32'h3, 32'h3},
        '{8'h1c, 32'h1234_5678, 32'h5678},
        '{8'h20, 32'h9abc_def0, 32'hdef0},
        '{8'h28, 32'h1232, 32'h1232}, '{8'h3c, 32'hffff, 32'h0},
        '{8'h00, 32'h300, 32'h0}};
    logic [7:0] regs [6] = '{8'h08, 8'h0c, 8'h1c, 8'h20, 8'h28, 8'h2c};

    always #4 clk_i = ~clk_i;

    ccsl_loader i_ccsl_loader (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
        .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .sync_a_i(sync_a_i),
        .sync_b_i(sync_b_i), .ram_idle_i(ram_idle_i), .ram_we_o(ram_we_o),
        .ram_addr_o(ram_addr_o), .ram_data_o(ram_data_o),
        .stage_ram_count_o(stage_ram_count_o), .irq_o(irq_o));
    ccsl_ram_model i_ccsl_ram_model (.clk_i(clk_i), .busy_i(busy),
        .ram_we_i(ram_we_o), .ram_addr_i(ram_addr_o),
        .ram_data_i(ram_data_o), .ram_idle_o(ram_idle_i));

    // ============================================================
    // helpers
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h want %h", $time, seen, exp);
        end
    endtask : check

    // one classic cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        r = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        wb(1'b1, a, d, r);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        wb(1'b0, a, 32'h0, r);
        check(r, e);
    endtask : rdc

    task automatic wait_writes(input int n);
        while (i_ccsl_ram_model.n_writes < n) @(posedge clk_i);
        repeat (2) @(posedge clk_i);
    endtask : wait_writes

    function automatic logic [31:0] val(input int s, input int i);
        return 32'(s * 16'h1000 + i + 16'h0011);
    endfunction : val

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            report_and_stop();
        end
    end

    // ============================================================
    // main sequence
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (rows[k]) begin
            wr(rows[k].a, rows[k].w);
            rdc(rows[k].a, rows[k].e);
        end
        check(32'(stage_ram_count_o), 32'h1232);
        $display("test registers done");
        rst_i <= 1'b1;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (regs[k]) rdc(regs[k], 32'h0);
        check(32'(stage_ram_count_o), 32'h0);
        $display("test reset done");
        wr(8'h00, 32'h0);
        wr(8'h04, 32'h111);
        wr(8'h04, 32'h456);
        wr(8'h04, 32'h321);
        rdc(8'h00, 32'h3);
        wr(8'h00, 32'h2);
        wr(8'h04, 32'h0aa);
        wr(8'h00, 32'h1);
        wr(8'h04, 32'h0bb);
        wr(8'h00, 32'h0);
        rdc(8'h04, 32'h111);
        rdc(8'h04, 32'h0bb);
        rdc(8'h04, 32'h0aa);
        rdc(8'h00, 32'h3);
        wr(8'h00, 32'h2ff);
        wr(8'h04, 32'h777);
        rdc(8'h00, 32'h0);
        $display("test pointer done");
        for (int s = 0; s < 3; s++) begin
            wr(8'h00, 32'(s * 256));
            for (int i = 0; i < 3; i++) wr(8'h04, val(s, i));
        end
        wr(8'h30, 32'h50);
        wr(8'h08, 32'h3);
        wr(8'h0c, 32'h5);
        wr(8'h10, 32'h0);
        busy <= 8'h01;
        wr(8'h14, 32'h1);
        repeat (10) @(posedge clk_i);
        check(32'(i_ccsl_ram_model.n_writes), 32'h0);
        wr(8'h14, 32'h1);
        busy <= 8'h00;
        wait_writes(9);
        repeat (20) @(posedge clk_i);
        check(32'(i_ccsl_ram_model.n_writes), 32'd9);
        for (int s = 0; s < 3; s++) begin
            for (int i = 0; i < 3; i++) begin
                check(32'(i_ccsl_ram_model.mem[0][s*256+i]), val(s, i));
                check(32'(i_ccsl_ram_model.mem[2][s*256+i]), val(s, i));
            end
        end
        check(32'(i_ccsl_ram_model.mem[1][0]), 32'h0000xxxx);
        check(32'(irq_o), 32'h1);
        rdc(8'h2c, 32'h40);
        wr(8'h2c, 32'h40);
        rdc(8'h2c, 32'h0);
        check(32'(irq_o), 32'h0);
        $display("test copy done");
        wr(8'h20, 32'd20);
        wr(8'h1c, 32'h0);
        wr(8'h18, 32'h0);
        for (int k = 1; k < 4; k++) begin
            base = i_ccsl_ram_model.n_writes;
            wr(8'h10, 32'(k));
            if (k == 1) begin
                wr(8'h24, 32'h1);
                wr(8'h14, 32'h2);
            end
            sync_a_i <= (k == 2);
            sync_b_i <= (k == 3);
            repeat (4) @(posedge clk_i);
            sync_a_i <= 1'b0;
            sync_b_i <= 1'b0;
            wait_writes(base + 9);
            check(32'(i_ccsl_ram_model.n_writes), 32'(base + 9));
            rdc(8'h2c, k == 1 ? 32'h50 : 32'h40);
            wr(8'h2c, 32'h50);
        end
        rdc(8'h34, 32'h0);
        $display("test sources done");
        wr(8'h10, 32'h0);
        wr(8'h18, 32'h8000);
        wr(8'h14, 32'h2);
        repeat (30) @(posedge clk_i);
        rdc(8'h2c, 32'h10);
        check(32'(irq_o), 32'h1);
        wr(8'h2c, 32'h10);
        repeat (30) @(posedge clk_i);
        rdc(8'h34, 32'h8);
        rdc(8'h2c, 32'h10);
        wr(8'h24, 32'h0);
        $display("test periodic done");
        report_and_stop();
    end
endmodule : ccsl_loader_test

bind ccsl_loader ccsl_loader_props #(.NUM_RAMS(NUM_RAMS)) i_ccsl_loader_props (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o),
    .ram_idle_i(ram_idle_i), .ram_we_o(ram_we_o), .ram_addr_o(ram_addr_o),
    .stage_ram_count_o(stage_ram_count_o), .irq_o(irq_o));
